// ==== src/dtc_timer_top.v ====
// Two 8-bit timer/counters with separate prescalers, compare output and PWM, behind an APB slave.
// Assumes i_clk is the fast peripheral tick; the system tick is every sixteenth edge of it.
//
// Overview of operation
// - Timer zero select: stop, tick, prescaled, pin edges.
// - Pin edges count even when pin drives.
// - Count pin synchronised; one tick between transitions.
// - Each timer owns a separate ten-bit prescaler.
// - Timer zero prescaler reset bit self-clears.
// - Timer one prescaler reset bit self-clears.
// - Force compare acts without flag or clear.
// - Force compare ignored in PWM mode.
// - Written timer zero count resumes next tick.
// - Timer one count write lands one tick later.
// - Clear-on-match zeroes timer one after match; here in normal mode only, PWM mode ignores it.
// - PWM enable bit selects PWM mode.
// - Normal mode pin: off, toggle, low, high.
// - Pin driven only when direction is output.
// - Timer one select: fast taps, tick, prescaled.
// - Fast tick is sixteen times system tick.
// - Normal mode compares against value A only.
// - PWM counts zero to top value, restarts.
// - PWM zero constant; one gives two ticks.
// - Reserved control bits read zero.
// - Compare flag follows match; writes never match.
// - PWM compare writes held until top.
// - PWM pin cleared or set on match.
//
// Chosen here: the APB register port.
`include "dtc_defs.vh"

module dtc_timer_top (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output reg         o_pslverr,
  input  wire        i_ext_count_pin,
  output reg         o_compare_pin_out,
  output reg         o_compare_pin_oe_b,
  output wire [7:0]  o_timer_zero_count,
  output wire [7:0]  o_timer_one_count
);

  localparam integer FAST_LAST_I = `DTC_FAST_PER_SYS - 1;
  localparam [3:0]   FAST_LAST   = FAST_LAST_I[3:0];

  function addr_is;
    input [7:0] addr;
    input [7:0] offs;
    begin
      addr_is = (addr == offs);
    end
  endfunction

  // Reset release through two flops.
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_b;

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_b = rst_sync_q;

  // System tick derived from the fast tick.
  reg  [3:0] fast_div_q;
  wire       sys_tick;

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast_div_q <= 4'h0;
    end else begin
      fast_div_q <= fast_div_q + 4'h1;
    end
  end
  assign sys_tick = (fast_div_q == FAST_LAST);

  // External count pin: two flops, then an edge detector on the second.
  reg ext_meta_q;
  reg ext_sync_q;
  reg ext_prev_q;

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= i_ext_count_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  // The pin is read from its input buffer, so a driven pin still counts.
  wire ext_rise = ext_sync_q & ~ext_prev_q;
  wire ext_fall = ~ext_sync_q & ext_prev_q;

  // Bus decode.
  wire wr_en = i_psel & i_penable & i_pwrite;
  wire setup = i_psel & ~i_penable;

  // Registers.
  reg [2:0] t0_cs_q;
  reg [7:0] t0_cnt_q;
  reg [7:0] t1_ctrl_q;
  reg [7:0] t1_cnt_q;
  reg [7:0] cmp_hold_q;
  reg [7:0] cmp_act_q;
  reg [7:0] pwm_top_q;
  reg [2:0] flags_q;
  reg [1:0] port_q;
  reg       t1_load_pend_q;
  reg [7:0] t1_load_val_q;
  reg       match_q;
  reg       oc_level_q;

  wire       clear_on_match = t1_ctrl_q[`DTC_T1_CLEAR_ON_MATCH];
  wire       pwm_mode       = t1_ctrl_q[`DTC_T1_PWM_ENABLE];
  wire [1:0] com            = t1_ctrl_q[`DTC_T1_COM_HI:`DTC_T1_COM_LO];
  wire [3:0] t1_cs          = t1_ctrl_q[`DTC_T1_CS_MSB:0];

  wire wr_sf     = wr_en & addr_is(i_paddr, `DTC_ADDR_SPECIAL_FUNC);
  wire psc0_clr  = wr_sf & i_pwdata[`DTC_SF_T0_PSC_RESET];
  wire psc1_clr  = wr_sf & i_pwdata[`DTC_SF_T1_PSC_RESET];
  wire force_cmp = wr_sf & i_pwdata[`DTC_SF_FORCE_CMP_A] & ~pwm_mode;
  wire wr_t0cnt  = wr_en & addr_is(i_paddr, `DTC_ADDR_T0_COUNT);
  wire wr_t1cnt  = wr_en & addr_is(i_paddr, `DTC_ADDR_T1_COUNT);
  wire wr_cmp    = wr_en & addr_is(i_paddr, `DTC_ADDR_COMPARE_A);
  wire wr_flags  = wr_en & addr_is(i_paddr, `DTC_ADDR_FLAGS);

  // Separate prescalers, both fed by the system tick.
  wire [`DTC_PSC_BITS:0] psc0_tap;
  wire [`DTC_PSC_BITS:0] psc1_tap;

  dtc_prescaler #(.W(`DTC_PSC_BITS)) u_psc0 (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_inc   (sys_tick),
    .i_clr   (psc0_clr),
    .o_tap   (psc0_tap)
  );

  dtc_prescaler #(.W(`DTC_PSC_BITS)) u_psc1 (
    .i_clk   (i_clk),
    .i_rst_b (rst_b),
    .i_inc   (sys_tick),
    .i_clr   (psc1_clr),
    .o_tap   (psc1_tap)
  );

  // Timer zero tick selection.
  reg t0_tick;
  always @* begin
    case (t0_cs_q)
      3'h1:    t0_tick = sys_tick;
      3'h2:    t0_tick = psc0_tap[3];
      3'h3:    t0_tick = psc0_tap[6];
      3'h4:    t0_tick = psc0_tap[8];
      3'h5:    t0_tick = psc0_tap[10];
      3'h6:    t0_tick = ext_fall;
      3'h7:    t0_tick = ext_rise;
      default: t0_tick = 1'b0;
    endcase
  end

  // Timer one tick selection; the fast taps cannot be reset, they share the system tick divider.
  reg t1_tick;
  always @* begin
    case (t1_cs)
      4'h0:    t1_tick = 1'b0;
      4'h1:    t1_tick = 1'b1;
      4'h2:    t1_tick = fast_div_q[0];
      4'h3:    t1_tick = &fast_div_q[1:0];
      4'h4:    t1_tick = &fast_div_q[2:0];
      4'h5:    t1_tick = sys_tick;
      default: t1_tick = psc1_tap[t1_cs - 4'h5];
    endcase
  end

  // Timer zero counter; a write takes the cycle, the next selected tick counts on.
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      t0_cnt_q <= `DTC_RST_BYTE;
    end else if (wr_t0cnt) begin
      t0_cnt_q <= i_pwdata[7:0];
    end else if (t0_tick) begin
      t0_cnt_q <= t0_cnt_q + 8'h01;
    end
  end

  // Timer one next count when a tick comes.
  wire       t1_at_top = pwm_mode & (t1_cnt_q == pwm_top_q);
  wire [7:0] t1_next   = t1_at_top ? 8'h00 : t1_cnt_q + 8'h01;
  wire       t1_wrap   = t1_tick & (t1_at_top | (~pwm_mode & (t1_cnt_q == 8'hff)));
  // Only counting can reach the compare value; loads never raise a match.
  wire       t1_match  = t1_tick & ~t1_load_pend_q & (t1_next == cmp_act_q);

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_cnt_q       <= `DTC_RST_BYTE;
      t1_load_pend_q <= 1'b0;
      t1_load_val_q  <= `DTC_RST_BYTE;
      match_q        <= 1'b0;
    end else begin
      match_q <= t1_match;
      if (wr_t1cnt) begin
        t1_load_pend_q <= 1'b1;
        t1_load_val_q  <= i_pwdata[7:0];
      end else if (sys_tick) begin
        t1_load_pend_q <= 1'b0;
      end
      if (t1_load_pend_q & sys_tick) begin
        t1_cnt_q <= t1_load_val_q;
      end else if (match_q & clear_on_match & ~pwm_mode) begin
        t1_cnt_q <= 8'h00;
      end else if (t1_tick) begin
        t1_cnt_q <= t1_next;
      end
    end
  end

  // Compare value A: holding copy for reads, active copy for compares.
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_hold_q <= `DTC_RST_BYTE;
      cmp_act_q  <= `DTC_RST_BYTE;
    end else begin
      if (wr_cmp) begin
        cmp_hold_q <= i_pwdata[7:0];
      end
      if (wr_cmp & ~pwm_mode) begin
        cmp_act_q <= i_pwdata[7:0];
      end else if (pwm_mode & t1_tick & t1_at_top) begin
        cmp_act_q <= cmp_hold_q;
      end
    end
  end

  // Compare pin level.
  wire pwm_low_const  = (cmp_act_q == 8'h00);
  wire pwm_high_const = (cmp_act_q == pwm_top_q);
  reg  oc_level_d;

  always @* begin
    oc_level_d = oc_level_q;
    if (pwm_mode) begin
      if (com[1]) begin
        if (pwm_low_const) begin
          oc_level_d = com[0];
        end else if (pwm_high_const) begin
          oc_level_d = ~com[0];
        end else if (t1_tick & t1_at_top) begin
          oc_level_d = ~com[0];
        end else if (t1_tick & (t1_cnt_q == cmp_act_q)) begin
          oc_level_d = com[0];
        end
      end
    end else if (match_q | force_cmp) begin
      case (com)
        2'h1:    oc_level_d = ~oc_level_q;
        2'h2:    oc_level_d = 1'b0;
        2'h3:    oc_level_d = 1'b1;
        default: oc_level_d = oc_level_q;
      endcase
    end
  end

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_level_q <= 1'b0;
    end else begin
      oc_level_q <= oc_level_d;
    end
  end

  wire timer_owns_pin = pwm_mode ? com[1] : (com != 2'h0);

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_compare_pin_out  <= 1'b0;
      o_compare_pin_oe_b <= 1'b1;
    end else begin
      o_compare_pin_oe_b <= ~port_q[`DTC_PORT_DIR];
      o_compare_pin_out  <= timer_owns_pin ? oc_level_q : port_q[`DTC_PORT_LEVEL];
    end
  end

  // Control, flags and port registers. Hardware setting a flag wins over a clear in the same cycle.
  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      t0_cs_q   <= 3'h0;
      t1_ctrl_q <= `DTC_RST_T1_CONTROL;
      pwm_top_q <= `DTC_RST_BYTE;
      port_q    <= 2'h0;
      flags_q   <= 3'h0;
    end else begin
      if (wr_en & addr_is(i_paddr, `DTC_ADDR_T0_CONTROL)) begin
        t0_cs_q <= i_pwdata[`DTC_T0_CS_MSB:0];
      end
      if (wr_en & addr_is(i_paddr, `DTC_ADDR_T1_CONTROL)) begin
        t1_ctrl_q <= i_pwdata[7:0];
      end
      if (wr_en & addr_is(i_paddr, `DTC_ADDR_PWM_TOP)) begin
        pwm_top_q <= i_pwdata[7:0];
      end
      if (wr_en & addr_is(i_paddr, `DTC_ADDR_PORT)) begin
        port_q <= i_pwdata[1:0];
      end
      flags_q[`DTC_FLAG_T0_OVF] <= (t0_tick & (t0_cnt_q == 8'hff) & ~wr_t0cnt) |
                                   (flags_q[`DTC_FLAG_T0_OVF] & ~(wr_flags & i_pwdata[`DTC_FLAG_T0_OVF]));
      flags_q[`DTC_FLAG_T1_OVF] <= t1_wrap |
                                   (flags_q[`DTC_FLAG_T1_OVF] & ~(wr_flags & i_pwdata[`DTC_FLAG_T1_OVF]));
      flags_q[`DTC_FLAG_T1_CMP_A] <= match_q |
                                     (flags_q[`DTC_FLAG_T1_CMP_A] & ~(wr_flags & i_pwdata[`DTC_FLAG_T1_CMP_A]));
    end
  end

  // Read mux, captured in the setup phase so the access phase returns registered data.
  reg [7:0] rd_byte;
  reg       rd_hit;

  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (i_paddr)
      `DTC_ADDR_T1_COUNT:     rd_byte = t1_cnt_q;
      `DTC_ADDR_T0_CONTROL:   rd_byte = {5'h00, t0_cs_q};
      `DTC_ADDR_T0_COUNT:     rd_byte = t0_cnt_q;
      `DTC_ADDR_SPECIAL_FUNC: rd_byte = `DTC_RST_SPECIAL_FUNC;
      `DTC_ADDR_T1_CONTROL:   rd_byte = t1_ctrl_q;
      `DTC_ADDR_COMPARE_A:    rd_byte = cmp_hold_q;
      `DTC_ADDR_PWM_TOP:      rd_byte = pwm_top_q;
      `DTC_ADDR_FLAGS:        rd_byte = {5'h00, flags_q};
      `DTC_ADDR_PORT:         rd_byte = {6'h00, port_q};
      default:                rd_hit  = 1'b0;
    endcase
  end

  always @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      o_pslverr <= ~rd_hit;
    end
  end

  // Every access completes in its first access cycle.
  assign o_pready           = 1'b1;
  assign o_timer_zero_count = t0_cnt_q;
  assign o_timer_one_count  = t1_cnt_q;

endmodule

// ==== src/dtc_defs.vh ====
// Constants for the dual timer/counter block: register map, field positions, reset values, timing.
// Assumes an APB slave with 32-bit data and byte addresses, one register per aligned word.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// Register byte addresses.
`define DTC_ADDR_T1_COUNT     8'h20
`define DTC_ADDR_T0_CONTROL   8'h24
`define DTC_ADDR_T0_COUNT     8'h28
`define DTC_ADDR_SPECIAL_FUNC 8'h2c
`define DTC_ADDR_T1_CONTROL   8'h30
`define DTC_ADDR_COMPARE_A    8'h38
`define DTC_ADDR_PWM_TOP      8'h3c
`define DTC_ADDR_FLAGS        8'h40
`define DTC_ADDR_PORT         8'h44

// Special function control fields.
`define DTC_SF_T0_PSC_RESET   0
`define DTC_SF_T1_PSC_RESET   1
`define DTC_SF_FORCE_CMP_A    2

// Timer one control fields.
`define DTC_T1_CLEAR_ON_MATCH 7
`define DTC_T1_PWM_ENABLE     6
`define DTC_T1_COM_HI         5
`define DTC_T1_COM_LO         4
`define DTC_T1_CS_MSB         3

// Timer zero control field.
`define DTC_T0_CS_MSB         2

// Flag register fields, cleared by writing one.
`define DTC_FLAG_T0_OVF       0
`define DTC_FLAG_T1_OVF       1
`define DTC_FLAG_T1_CMP_A     2

// Port register fields for the compare pin.
`define DTC_PORT_DIR          0
`define DTC_PORT_LEVEL        1

// Reset values.
`define DTC_RST_SPECIAL_FUNC  8'h00
`define DTC_RST_T1_CONTROL    8'h00
`define DTC_RST_T0_CONTROL    8'h00
`define DTC_RST_BYTE          8'h00

// Fast peripheral ticks per system tick and prescaler width.
`define DTC_FAST_PER_SYS      16
`define DTC_PSC_BITS          10

`endif

// ==== src/dtc_prescaler.v ====
// Ten-bit ripple-free prescaler that turns an input tick into divided tick pulses.
// Assumes i_rst_b is already synchronised to i_clk; o_tap[k] pulses once per 2**k input ticks.
module dtc_prescaler #(
  parameter W = 10
) (
  input  wire         i_clk,
  input  wire         i_rst_b,
  input  wire         i_inc,
  input  wire         i_clr,
  output wire [W:0]   o_tap
);

  reg  [W-1:0] cnt_q;
  wire [W-1:0] cnt_d;

  // A clear wins over a pending tick so the divided phase restarts cleanly.
  assign cnt_d = i_clr ? {W{1'b0}} : (i_inc ? cnt_q + 1'b1 : cnt_q);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_tap[0] = i_inc & ~i_clr;

  genvar k;
  generate
    for (k = 1; k <= W; k = k + 1) begin : g_tap
      assign o_tap[k] = i_inc & ~i_clr & (&cnt_q[k-1:0]);
    end
  endgenerate

endmodule

// ==== test/dtc_pin_model.sv ====
// Outside driver of the timer zero count pin: one high pulse per request.
// Assumes requests come no faster than one pulse takes.
module dtc_pin_model (
  input  wire  i_clk,
  input  wire  i_go,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pin = 1'b0;
  always @(posedge i_clk) begin
    if (i_go) begin
      o_pin <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_pin <= 1'b0;
    end
  end
endmodule

// ==== test/dtc_properties.sv ====
// Checker of the timer block's bus answers and count steps.
// Assumes pready is tied high, so every access phase lasts one cycle.
module dtc_properties (
  input logic        i_clk,
  input logic        i_rst_b,
  input logic        i_psel,
  input logic        i_penable,
  input logic        i_pwrite,
  input logic [7:0]  i_paddr,
  input logic [31:0] i_pwdata,
  input logic [31:0] o_prdata,
  input logic        o_pready,
  input logic        o_pslverr,
  input logic        i_ext_count_pin,
  input logic        o_compare_pin_out,
  input logic        o_compare_pin_oe_b,
  input logic [7:0]  o_timer_zero_count,
  input logic [7:0]  o_timer_one_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire acc = i_psel && i_penable;
  wire rd  = acc && !i_pwrite;
  wire wr  = acc && i_pwrite;
  wire map = i_paddr inside {8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h3c, 8'h40, 8'h44};
  property p_ready; o_pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc && !map |-> o_pslverr; endproperty
  a_err: assert property (p_err) else $error("no error on unmapped");
  property p_ok; acc && map |-> !o_pslverr; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped");
  property p_hi; rd |-> o_prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_sf; rd && i_paddr == 8'h2c |-> o_prdata == 32'h0; endproperty
  a_sf: assert property (p_sf) else $error("special reg not zero");
  property p_t0c; rd && i_paddr == 8'h24 |-> o_prdata[7:3] == 5'h0; endproperty
  a_t0c: assert property (p_t0c) else $error("reserved bits set");
  property p_t0; $changed(o_timer_zero_count) |->
    o_timer_zero_count == $past(o_timer_zero_count) + 8'h01 || $past(wr && i_paddr == 8'h28); endproperty
  a_t0: assert property (p_t0) else $error("timer zero bad step");
  property p_oe; $fell(o_compare_pin_oe_b) |->
    $past(wr && i_paddr == 8'h44) || $past(wr && i_paddr == 8'h44, 2); endproperty
  a_oe: assert property (p_oe) else $error("pin driven unasked");
  property p_oe_off; $rose(o_compare_pin_oe_b) |-> $past(wr && i_paddr == 8'h44, 2); endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin released unasked");
  c_sf: cover property (rd && i_paddr == 8'h2c);
  c_oe: cover property ($fell(o_compare_pin_oe_b));
  c_t0: cover property ($changed(o_timer_zero_count));
endmodule

// ==== test/testbench.sv ====
// Bench for the dual timer block: APB tasks, queued read checks and port scenarios.
// Assumes the pin model drives the count pin and the checker is bound below.
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic        pin_go = 1'b0;
  wire         i_ext_count_pin;
  wire  [31:0] o_prdata;
  wire         o_pready;
  wire         o_pslverr;
  wire         o_compare_pin_out;
  wire         o_compare_pin_oe_b;
  wire  [7:0]  o_timer_zero_count;
  wire  [7:0]  o_timer_one_count;
  logic [32:0] q[$];
  logic [32:0] ev;
  logic [7:0]  c;
  logic [7:0]  v;
  logic [7:0]  mx;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          m;
  int          i;
  int          h;
  int          dv[6] = '{0, 1, 8, 64, 256, 1024};
  logic        pe[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  always #12.5 i_clk = ~i_clk;
  dtc_timer_top u_dut (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_ext_count_pin, .o_compare_pin_out, .o_compare_pin_oe_b,
    .o_timer_zero_count, .o_timer_one_count);
  dtc_pin_model u_pin (.i_clk, .i_go(pin_go), .o_pin(i_ext_count_pin));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse;
    pin_go <= 1'b1;
    @(posedge i_clk);
    pin_go <= 1'b0;
    repeat (10) @(posedge i_clk);
  endtask
  // Counts pin-high cycles and the largest timer one count over a window.
  task automatic measure(input int n);
    h = 0;
    mx = 8'h00;
    repeat (n) begin
      @(negedge i_clk);
      h += int'(o_compare_pin_out);
      if (o_timer_one_count > mx) mx = o_timer_one_count;
    end
  endtask
  always @(posedge i_clk) begin
    if (i_psel && i_penable && !i_pwrite && q.size() > 0) begin
      ev = q.pop_front();
      `CHK("prdata", ev, {o_pslverr, o_prdata})
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(37308));
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(8'h24, 33'h0);
    rd(8'h30, 33'h0);
    rd(8'h00, 33'h1_0000_0000);
    wr(8'h24, 32'hff);
    rd(8'h24, 33'h7);
    wr(8'h2c, 32'hf8);
    rd(8'h2c, 33'h0);
    for (m = 6; m < 8; m++) begin
      wr(8'h24, m);
      wr(8'h28, 32'h0);
      repeat (5) pulse();
      rd(8'h28, 33'h5);
    end
    // The prescaler reset only fixes the divided phase, so one count of slack is allowed.
    for (m = 1; m < 6; m++) begin
      wr(8'h24, 32'h0);
      wr(8'h28, 32'h0);
      wr(8'h2c, 32'h1);
      wr(8'h24, m);
      repeat (32 * dv[m]) @(negedge i_clk);
      `CHK("t0 rate", 1'b1, o_timer_zero_count inside {8'h01, 8'h02})
    end
    wr(8'h24, 32'h0);
    v = 8'($urandom);
    wr(8'h28, {24'h0, v});
    repeat (40) @(posedge i_clk);
    rd(8'h28, {25'h0, v});
    for (m = 1; m < 9; m++) begin
      wr(8'h30, m);
      @(negedge i_clk);
      c = o_timer_one_count;
      repeat (10 << (m - 1)) @(negedge i_clk);
      `CHK("t1 rate", 8'h0a, 8'(o_timer_one_count - c))
    end
    wr(8'h30, 32'h1);
    wr(8'h40, 32'h7);
    repeat (300) @(posedge i_clk);
    rd(8'h40, 33'h6);
    wr(8'h30, 32'h0);
    v = 8'($urandom);
    wr(8'h38, {24'h0, v});
    wr(8'h40, 32'h7);
    wr(8'h20, {24'h0, v});
    for (i = 0; i < 17 && o_timer_one_count !== v; i++) @(negedge i_clk);
    `CHK("t1 load", v, o_timer_one_count)
    rd(8'h40, 33'h0);
    wr(8'h44, 32'h1);
    for (m = 3; m >= 0; m--) begin
      wr(8'h30, 32'h80 | (m << 4));
      wr(8'h2c, 32'h4);
      repeat (3) @(negedge i_clk);
      `CHK("pin", pe[m], o_compare_pin_out)
    end
    `CHK("oe", 1'b0, o_compare_pin_oe_b)
    rd(8'h40, 33'h0);
    rd(8'h20, {25'h0, v});
    wr(8'h44, 32'h0);
    repeat (3) @(negedge i_clk);
    `CHK("oe", 1'b1, o_compare_pin_oe_b)
    wr(8'h38, 32'h10);
    wr(8'h20, 32'h0);
    repeat (20) @(posedge i_clk);
    wr(8'h40, 32'h7);
    wr(8'h30, 32'h85);
    measure(400);
    `CHK("t1 max", 8'h10, mx)
    rd(8'h40, 33'h4);
    wr(8'h44, 32'h1);
    wr(8'h3c, 32'h9);
    wr(8'h38, 32'h3);
    for (m = 2; m < 4; m++) begin
      wr(8'h30, 32'h41 | (m << 4));
      measure(300);
      measure(100);
      `CHK("pwm high", (m == 2) ? 40 : 60, h)
      `CHK("pwm top", 8'h09, mx)
    end
    wr(8'h38, 32'h0);
    rd(8'h38, 33'h0);
    measure(300);
    measure(100);
    `CHK("pwm zero", 100, h)
    wr(8'h30, 32'h51);
    wr(8'h2c, 32'h4);
    measure(100);
    `CHK("pwm force", 0, h)
    // Compare at the top value holds the pin high, so a forced clear would show as a low cycle.
    wr(8'h38, 32'h9);
    wr(8'h30, 32'h61);
    measure(30);
    rd(8'h38, 33'h9);
    wr(8'h2c, 32'h4);
    measure(100);
    `CHK("pwm force held", 100, h)
    wr(8'h38, 32'h1);
    measure(30);
    measure(100);
    `CHK("pwm one", 20, h)
    wrap_up();
  end
endmodule
bind dtc_timer_top dtc_properties u_chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_ext_count_pin, .o_compare_pin_out,
  .o_compare_pin_oe_b, .o_timer_zero_count, .o_timer_one_count);
